// ===== logic/dce_arbiter.sv
// Purpose: pick the next channel item and settle it against the processor
// Assumes: start pulses when the engine accepts winIdx
// Notes:   priority code 3 counts as high
`timescale 1ns/100ps
module dce_arbiter (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [4:0] chanReq,
  input  wire logic [9:0] chanPrio,
  input  wire logic       cpuReq,
  input  wire logic       busBusy,
  input  wire logic       start,
  output logic            winValid,
  output logic      [2:0] winIdx,
  output logic            cpuGnt
);
  logic [2:0] rr_ff;
  logic [2:0] nxt_rr;
  logic       alt_ff;
  logic       nxt_alt;
  logic [1:0] best;
  logic       found;
  logic       go;
  logic [2:0] idx;

  function automatic logic [1:0] lvl(input logic [9:0] p, input int i);
    logic [1:0] v;
    v = p[2*i +: 2];
    lvl = (v >= dce_pkg::PRIO_HIGH) ? dce_pkg::PRIO_HIGH : v;
  endfunction

  always_comb begin
    best  = dce_pkg::PRIO_LOW;
    found = 1'b0;
    winIdx = 3'h0;
    idx = rr_ff;
    for (int i = 0; i < dce_pkg::NCH; i++) begin
      if (chanReq[i] && lvl(chanPrio, i) > best) begin
        best = lvl(chanPrio, i);
      end
    end
    // Round robin starts just past the last winner
    for (int k = 0; k < dce_pkg::NCH; k++) begin
      idx = (idx == 3'h4) ? 3'h0 : idx + 3'h1;
      if (!found && chanReq[idx] && lvl(chanPrio, 32'(idx)) == best) begin
        found  = 1'b1;
        winIdx = idx;
      end
    end
    if (!cpuReq) begin
      go = 1'b1;
    end else begin
      case (best)
        dce_pkg::PRIO_HIGH:   go = 1'b1;
        dce_pkg::PRIO_NORMAL: go = alt_ff;
        default:              go = 1'b0;
      endcase
    end
    winValid = found && go && !busBusy;
    cpuGnt   = cpuReq && !busBusy && !winValid;
    nxt_rr   = start ? winIdx : rr_ff;
    nxt_alt  = alt_ff;
    if (found && cpuReq && !busBusy && best == dce_pkg::PRIO_NORMAL) begin
      nxt_alt = !alt_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rr_ff  <= 3'h4;
      alt_ff <= 1'b1;
    end else begin
      rr_ff  <= nxt_rr;
      alt_ff <= nxt_alt;
    end
  end

  high_beats_cpu_a: assert property (@(posedge clk) disable iff (srst)
    (cpuGnt |-> !(found && best == dce_pkg::PRIO_HIGH)))
    else $error("processor granted over a high priority channel");

  low_yields_a: assert property (@(posedge clk) disable iff (srst)
    (winValid && cpuReq |-> best != dce_pkg::PRIO_LOW))
    else $error("low priority channel beat the processor");

  normal_turns_a: assert property (@(posedge clk) disable iff (srst)
    (cpuGnt && found && best == dce_pkg::PRIO_NORMAL ##1
     found && cpuReq && !busBusy && best == dce_pkg::PRIO_NORMAL
     |-> winValid))
    else $error("normal priority channel lost twice in a row");
endmodule

// ===== logic/dce_engine.sv
// Purpose: five-channel descriptor driven memory copy engine
// Assumes: memRdata is valid the cycle after a read request
// Notes:   one item in flight at a time, read then capture then write
`timescale 1ns/100ps
module dce_engine (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        armWrite,
  input  wire logic [4:0]  channelArmBit,
  input  wire logic        abortReq,
  input  wire logic [4:0]  softRequestBit,
  input  wire logic [31:0] trigIn,
  input  wire logic [15:0] chan0ConfigPointer,
  input  wire logic [15:0] chan1to4ConfigPointer,
  input  wire logic        cpuReq,
  output logic             cpuGnt,
  output logic             memReq,
  output logic             memWrite,
  output logic             memWord,
  output logic      [15:0] memAddr,
  output logic      [15:0] memWdata,
  input  wire logic [15:0] memRdata,
  input  wire logic [4:0]  flagClear,
  output logic      [4:0]  completionFlagReg,
  output logic      [4:0]  armedState,
  output logic             irqReq
);
  localparam int N = dce_pkg::NCH;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dce_pkg::dce_state_e state_ff, nxt_state;
  logic [63:0] cfg_ff    [N];
  logic [63:0] nxt_cfg   [N];
  logic [15:0] src_ff    [N];
  logic [15:0] nxt_src   [N];
  logic [15:0] dst_ff    [N];
  logic [15:0] nxt_dst   [N];
  logic [12:0] cnt_ff    [N];
  logic [12:0] nxt_cnt   [N];
  logic [12:0] tgt_ff    [N];
  logic [12:0] nxt_tgt   [N];
  logic [4:0]  armed_ff, nxt_armed;
  logic [4:0]  ready_ff, nxt_ready;
  logic [4:0]  pend_ff, nxt_pend;
  logic [4:0]  fetchPend_ff, nxt_fetchPend;
  logic [4:0]  flag_ff, nxt_flag;
  logic [4:0]  done_ff, nxt_done;
  logic [2:0]  cur_ff, nxt_cur;
  logic [3:0]  fetchByte_ff, nxt_fetchByte;
  logic [15:0] data_ff, nxt_data;
  logic        irq_ff, nxt_irq;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic [4:0]  trigHit;
  logic [9:0]  prioVec;
  logic [2:0]  fetchPick;
  logic [63:0] curCfg;
  logic [12:0] lenTarget;
  logic [12:0] cntInc;
  logic        winValid;
  logic [2:0]  winIdx;
  logic        busBusy;
  logic        start;

  function automatic logic [15:0] stepAddr(input logic [15:0] a,
                                           input logic [1:0]  code);
    case (code)
      dce_pkg::INC_ONE: stepAddr = a + 16'h1;
      dce_pkg::INC_TWO: stepAddr = a + 16'h2;
      dce_pkg::DEC_ONE: stepAddr = a - 16'h1;
      default:          stepAddr = a;
    endcase
  endfunction

  always_comb begin
    curCfg    = cfg_ff[cur_ff];
    fetchPick = 3'h0;
    // Channels 1..4 fetch before channel 0
    for (int i = N - 1; i >= 1; i--) begin
      if (fetchPend_ff[i]) begin
        fetchPick = 3'(i);
      end
    end
    for (int i = 0; i < N; i++) begin
      logic [4:0] sel;
      sel = cfg_ff[i][dce_pkg::TRIG_LSB +: 5];
      prioVec[2*i +: 2] = cfg_ff[i][dce_pkg::PRIO_LSB +: 2];
      if (sel == dce_pkg::TRIG_PREV) begin
        trigHit[i] = done_ff[(i + N - 1) % N];
      end else if (sel == dce_pkg::TRIG_NONE) begin
        trigHit[i] = 1'b0;
      end else begin
        trigHit[i] = trigIn[sel];
      end
    end
    cntInc = cnt_ff[cur_ff] + 13'h1;
  end

  assign busBusy = (state_ff != dce_pkg::ST_IDLE) || (|fetchPend_ff);
  assign start   = winValid;

  dce_arbiter u_arb (
    .clk      (clk),
    .srst     (srst),
    .chanReq  (pend_ff & ready_ff & armed_ff),
    .chanPrio (prioVec),
    .cpuReq   (cpuReq),
    .busBusy  (busBusy),
    .start    (start),
    .winValid (winValid),
    .winIdx   (winIdx),
    .cpuGnt   (cpuGnt)
  );

  dce_len_calc u_len (
    .firstItem          (memRdata),
    .wordMode           (curCfg[dce_pkg::WORD_BIT]),
    .lengthByteWidthSel (curCfg[dce_pkg::M8_BIT]),
    .varLengthOption    (curCfg[dce_pkg::VAR_LENGTH_OPTION_LSB +: 3]),
    .maxTransferCount   (curCfg[dce_pkg::LEN_LSB +: 13]),
    .target             (lenTarget)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state     = state_ff;
    nxt_cur       = cur_ff;
    nxt_fetchByte = fetchByte_ff;
    nxt_data      = data_ff;
    nxt_armed     = armed_ff;
    nxt_ready     = ready_ff;
    nxt_pend      = pend_ff;
    nxt_fetchPend = fetchPend_ff;
    nxt_flag      = flag_ff & ~flagClear;
    nxt_done      = 5'h00;
    nxt_irq       = 1'b0;
    nxt_cfg       = cfg_ff;
    nxt_src       = src_ff;
    nxt_dst       = dst_ff;
    nxt_cnt       = cnt_ff;
    nxt_tgt       = tgt_ff;

    // Triggers before the record is in are dropped
    for (int i = 0; i < N; i++) begin
      if (ready_ff[i] && (softRequestBit[i] || trigHit[i])) begin
        nxt_pend[i] = 1'b1;
      end
    end

    case (state_ff)
      dce_pkg::ST_IDLE: begin
        if (|fetchPend_ff) begin
          nxt_cur       = fetchPick;
          nxt_fetchByte = 4'h0;
          nxt_state     = dce_pkg::ST_FETCH;
        end else if (winValid) begin
          nxt_cur   = winIdx;
          nxt_state = dce_pkg::ST_READ;
        end
      end
      dce_pkg::ST_FETCH: begin
        nxt_fetchByte = fetchByte_ff + 4'h1;
        if (fetchByte_ff != 4'h0) begin
          nxt_cfg[cur_ff] = {cfg_ff[cur_ff][55:0], memRdata[7:0]};
        end
        if (fetchByte_ff == dce_pkg::FETCH_LAST) begin
          nxt_ready[cur_ff]     = 1'b1;
          nxt_fetchPend[cur_ff] = 1'b0;
          nxt_src[cur_ff] = nxt_cfg[cur_ff][dce_pkg::SRC_LSB +: 16];
          nxt_dst[cur_ff] = nxt_cfg[cur_ff][dce_pkg::DST_LSB +: 16];
          nxt_cnt[cur_ff] = dce_pkg::CNT_RST;
          nxt_tgt[cur_ff] = nxt_cfg[cur_ff][dce_pkg::LEN_LSB +: 13];
          nxt_pend[cur_ff] = 1'b0;
          nxt_state = dce_pkg::ST_IDLE;
        end
      end
      dce_pkg::ST_READ: begin
        nxt_state = dce_pkg::ST_CAPT;
      end
      dce_pkg::ST_CAPT: begin
        nxt_data = memRdata;
        if (cnt_ff[cur_ff] == dce_pkg::CNT_RST &&
            curCfg[dce_pkg::VAR_LENGTH_OPTION_LSB +: 3] != dce_pkg::VAR_LENGTH_OPTION_OFF) begin
          nxt_tgt[cur_ff] = lenTarget;
        end
        nxt_state = dce_pkg::ST_WRITE;
      end
      dce_pkg::ST_WRITE: begin
        nxt_state = dce_pkg::ST_IDLE;
        if (armed_ff[cur_ff]) begin
          nxt_src[cur_ff] = stepAddr(src_ff[cur_ff],
                                     curCfg[dce_pkg::SINC_LSB +: 2]);
          nxt_dst[cur_ff] = stepAddr(dst_ff[cur_ff],
                                     curCfg[dce_pkg::DINC_LSB +: 2]);
          nxt_cnt[cur_ff] = cntInc;
          // Single modes spend their trigger on one item
          if (!curCfg[dce_pkg::MODE_LSB]) begin
            nxt_pend[cur_ff] = 1'b0;
          end
          if (cntInc >= tgt_ff[cur_ff]) begin
            nxt_flag[cur_ff] = 1'b1;
            nxt_irq  = curCfg[dce_pkg::MASK_BIT];
            nxt_done[cur_ff] = 1'b1;
            nxt_pend[cur_ff] = 1'b0;
            if (curCfg[dce_pkg::MODE_LSB + 1]) begin
              nxt_src[cur_ff] = curCfg[dce_pkg::SRC_LSB +: 16];
              nxt_dst[cur_ff] = curCfg[dce_pkg::DST_LSB +: 16];
              nxt_cnt[cur_ff] = dce_pkg::CNT_RST;
              nxt_tgt[cur_ff] = curCfg[dce_pkg::LEN_LSB +: 13];
            end else begin
              nxt_armed[cur_ff] = 1'b0;
              nxt_ready[cur_ff] = 1'b0;
            end
          end
        end
      end
      default: begin
        nxt_state = dce_pkg::ST_IDLE;
      end
    endcase

    if (armWrite) begin
      if (abortReq) begin
        nxt_armed     = nxt_armed & ~channelArmBit;
        nxt_ready     = nxt_ready & ~channelArmBit;
        nxt_pend      = nxt_pend & ~channelArmBit;
        nxt_fetchPend = nxt_fetchPend & ~channelArmBit;
        if (state_ff == dce_pkg::ST_FETCH && channelArmBit[cur_ff]) begin
          nxt_state = dce_pkg::ST_IDLE;
        end
      end else begin
        nxt_armed     = nxt_armed | channelArmBit;
        nxt_fetchPend = nxt_fetchPend | (channelArmBit & ~armed_ff);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff     <= dce_pkg::ST_IDLE;
      cur_ff       <= 3'h0;
      fetchByte_ff <= 4'h0;
      data_ff      <= 16'h0000;
      armed_ff     <= 5'h00;
      ready_ff     <= 5'h00;
      pend_ff      <= 5'h00;
      fetchPend_ff <= 5'h00;
      flag_ff      <= 5'h00;
      done_ff      <= 5'h00;
      irq_ff       <= 1'b0;
      for (int i = 0; i < N; i++) begin
        cfg_ff[i] <= dce_pkg::CFG_RST;
        src_ff[i] <= dce_pkg::PTR_RST;
        dst_ff[i] <= dce_pkg::PTR_RST;
        cnt_ff[i] <= dce_pkg::CNT_RST;
        tgt_ff[i] <= dce_pkg::CNT_RST;
      end
    end else begin
      state_ff     <= nxt_state;
      cur_ff       <= nxt_cur;
      fetchByte_ff <= nxt_fetchByte;
      data_ff      <= nxt_data;
      armed_ff     <= nxt_armed;
      ready_ff     <= nxt_ready;
      pend_ff      <= nxt_pend;
      fetchPend_ff <= nxt_fetchPend;
      flag_ff      <= nxt_flag;
      done_ff      <= nxt_done;
      irq_ff       <= nxt_irq;
      cfg_ff       <= nxt_cfg;
      src_ff       <= nxt_src;
      dst_ff       <= nxt_dst;
      cnt_ff       <= nxt_cnt;
      tgt_ff       <= nxt_tgt;
    end
  end

  // ----------------------------------------------------------------------
  // Memory side
  // ----------------------------------------------------------------------
  always_comb begin
    memReq   = 1'b0;
    memWrite = 1'b0;
    memWord  = 1'b0;
    memAddr  = 16'h0000;
    case (state_ff)
      dce_pkg::ST_FETCH: begin
        memReq = fetchByte_ff != dce_pkg::FETCH_LAST;
        // Channels 1..4 share one contiguous table
        if (cur_ff == 3'h0) begin
          memAddr = chan0ConfigPointer + {12'h000, fetchByte_ff};
        end else begin
          memAddr = chan1to4ConfigPointer + {12'h000, fetchByte_ff} +
                    {10'h000, 3'(cur_ff - 3'h1), 3'h0};
        end
      end
      dce_pkg::ST_READ: begin
        memReq  = 1'b1;
        memWord = curCfg[dce_pkg::WORD_BIT];
        memAddr = src_ff[cur_ff];
      end
      dce_pkg::ST_WRITE: begin
        memReq   = 1'b1;
        memWrite = 1'b1;
        memWord  = curCfg[dce_pkg::WORD_BIT];
        memAddr  = dst_ff[cur_ff];
      end
      default: begin
        memReq = 1'b0;
      end
    endcase
  end

  assign memWdata          = data_ff;
  assign completionFlagReg = flag_ff;
  assign armedState        = armed_ff;
  assign irqReq            = irq_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence itemSeq;
    state_ff == dce_pkg::ST_CAPT ##1 state_ff == dce_pkg::ST_WRITE;
  endsequence

  item_steps_a: assert property (@(posedge clk) disable iff (srst)
    (state_ff == dce_pkg::ST_READ |=> itemSeq))
    else $error("item did not run read, capture, write");

  fetch_nine_a: assert property (@(posedge clk) disable iff (srst)
    (state_ff == dce_pkg::ST_FETCH && fetchByte_ff == 4'h0 && !armWrite
     ##1 !armWrite [*7] |=> fetchByte_ff == dce_pkg::FETCH_LAST))
    else $error("record fetch did not take nine clocks");

  abort_clears_a: assert property (@(posedge clk) disable iff (srst)
    (armWrite && abortReq |=> (armed_ff & $past(channelArmBit)) == 5'h00))
    else $error("aborted channel still armed");

  flag_sets_a: assert property (@(posedge clk) disable iff (srst)
    (|done_ff |-> (completionFlagReg & done_ff) == done_ff))
    else $error("completion flag missing after completion");

  irq_gated_a: assert property (@(posedge clk) disable iff (srst)
    (irqReq |-> |done_ff && $past(curCfg[dce_pkg::MASK_BIT])))
    else $error("interrupt without unmasked completion");

  once_disarm_a: assert property (@(posedge clk) disable iff (srst)
    (|done_ff && !$past(curCfg[dce_pkg::MODE_LSB + 1]) && !$past(armWrite)
     |-> (armed_ff & done_ff) == 5'h00))
    else $error("single or block channel still armed at completion");

  rearm_a: assert property (@(posedge clk) disable iff (srst)
    (|done_ff && $past(curCfg[dce_pkg::MODE_LSB + 1]) && !$past(armWrite)
     |-> (armed_ff & done_ff) == done_ff && cnt_ff[cur_ff] == 13'h0000))
    else $error("repeated channel not rearmed at completion");

  late_trig_a: assert property (@(posedge clk) disable iff (srst)
    (state_ff == dce_pkg::ST_IDLE && !armWrite && !busBusy &&
     (ready_ff[0] & softRequestBit[0]) |=> pend_ff[0]))
    else $error("software request on a ready channel lost");
endmodule

// ===== logic/dce_len_calc.sv
// Purpose: item count for a variable length transfer
// Assumes: firstItem is the first item read from the source
// Notes:   purely combinational
`timescale 1ns/100ps
module dce_len_calc (
  input  wire logic [15:0] firstItem,
  input  wire logic        wordMode,
  input  wire logic        lengthByteWidthSel,
  input  wire logic [2:0]  varLengthOption,
  input  wire logic [12:0] maxTransferCount,
  output logic      [12:0] target
);
  logic [13:0] raw;
  logic [13:0] sum;

  always_comb begin
    // Width select means nothing for words
    if (wordMode) begin
      raw = {1'b0, firstItem[12:0]};
    end else if (lengthByteWidthSel) begin
      raw = {6'h0, firstItem[7:0]};
    end else begin
      raw = {7'h0, firstItem[6:0]};
    end
    case (varLengthOption)
      dce_pkg::VAR_LENGTH_OPTION_PLUS1: sum = raw + 14'h1;
      dce_pkg::VAR_LENGTH_OPTION_PLAIN: sum = raw;
      dce_pkg::VAR_LENGTH_OPTION_PLUS2: sum = raw + 14'h2;
      dce_pkg::VAR_LENGTH_OPTION_PLUS3: sum = raw + 14'h3;
      default:             sum = {1'b0, maxTransferCount};
    endcase
    if (sum > {1'b0, maxTransferCount}) begin
      target = maxTransferCount;
    end else begin
      target = sum[12:0];
    end
  end
endmodule

// ===== logic/dce_pkg.sv
// Purpose: constants and types shared by the five-channel copy engine
// Assumes: one 25 MHz clock, memory answers a read on the next cycle
// Notes:   descriptor is eight bytes, byte 0 lands in bits 63:56

package dce_pkg;

  localparam int NCH = 5;

  // ----------------------------------------------------------------------
  // Descriptor field positions
  // ----------------------------------------------------------------------
  localparam int SRC_LSB  = 48;
  localparam int DST_LSB  = 32;
  localparam int VAR_LENGTH_OPTION_LSB = 29;
  localparam int LEN_LSB  = 16;
  localparam int WORD_BIT = 15;
  localparam int MODE_LSB = 13;
  localparam int TRIG_LSB = 8;
  localparam int SINC_LSB = 6;
  localparam int DINC_LSB = 4;
  localparam int MASK_BIT = 3;
  localparam int M8_BIT   = 2;
  localparam int PRIO_LSB = 0;

  // ----------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_SINGLE  = 2'h0;
  localparam logic [1:0] MODE_BLOCK   = 2'h1;
  localparam logic [1:0] MODE_RSINGLE = 2'h2;
  localparam logic [1:0] MODE_RBLOCK  = 2'h3;
  localparam logic [1:0] INC_ZERO     = 2'h0;
  localparam logic [1:0] INC_ONE      = 2'h1;
  localparam logic [1:0] INC_TWO      = 2'h2;
  localparam logic [1:0] DEC_ONE      = 2'h3;
  localparam logic [1:0] PRIO_LOW     = 2'h0;
  localparam logic [1:0] PRIO_NORMAL  = 2'h1;
  localparam logic [1:0] PRIO_HIGH    = 2'h2;
  localparam logic [2:0] VAR_LENGTH_OPTION_OFF     = 3'h0;
  localparam logic [2:0] VAR_LENGTH_OPTION_PLUS1   = 3'h1;
  localparam logic [2:0] VAR_LENGTH_OPTION_PLAIN   = 3'h2;
  localparam logic [2:0] VAR_LENGTH_OPTION_PLUS2   = 3'h3;
  localparam logic [2:0] VAR_LENGTH_OPTION_PLUS3   = 3'h4;
  localparam logic [4:0] TRIG_NONE    = 5'h00;
  localparam logic [4:0] TRIG_PREV    = 5'h01;

  // ----------------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0]  FETCH_LAST = 4'h8;
  localparam logic [15:0] REC_BYTES  = 16'h0008;
  localparam logic [63:0] CFG_RST    = 64'h0;
  localparam logic [15:0] PTR_RST    = 16'h0000;
  localparam logic [12:0] CNT_RST    = 13'h0000;

  typedef enum {ST_IDLE, ST_FETCH, ST_READ, ST_CAPT, ST_WRITE} dce_state_e;

endpackage

// ===== tb/dce_mem_model.sv
// Purpose: shared memory seen by the copy engine
// Assumes: 256 bytes, address wraps on the low byte
// Notes:   words are big-endian, read data one cycle late
`timescale 1ns/100ps
module dce_mem_model (
  input  wire logic        clk,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic        memWord,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic      [15:0] memRdata
);
  logic [7:0] mem [0:255];
  logic [7:0] a;
  initial for (int k = 0; k < 256; k++) mem[k] = 8'hee;
  assign a = memAddr[7:0];
  always @(posedge clk) begin
    // Idle cycles toggle so stale data never looks valid
    if (memReq === 1'b1 && memWrite === 1'b0)
      memRdata <= memWord ? {mem[a], mem[a + 8'h01]} : {8'h00, mem[a]};
    else
      memRdata <= ~memRdata;
    // Writes land blindly, bench keeps targets writable
    if (memReq === 1'b1 && memWrite === 1'b1) begin
      if (memWord === 1'b1) begin
        mem[a]         <= memWdata[15:8];
        mem[a + 8'h01] <= memWdata[7:0];
      end else begin
        mem[a] <= memWdata[7:0];
      end
    end
  end
endmodule

// ===== tb/tb_dce_engine.sv
// Purpose: directed tests of the copy engine
// Assumes: processor requests, triggers and flag clears driven by hand
// Notes:   descriptors are poked straight into the memory model
`timescale 1ns/100ps
module tb_dce_engine;
  logic        clk = 0, srst = 1, armWrite = 0, abortReq = 0, irqSeen;
  logic        cpuReq = 0;
  logic [4:0]  channelArmBit = 0, softRequestBit = 0, flags, armed;
  logic [4:0]  flagClear = 0;
  logic [31:0] trigIn = 0;
  logic        memReq, memWrite, memWord, cpuGnt, irqReq;
  logic [15:0] memAddr, memWdata, memRdata;
  int          bad_count = 0, num_checks = 0;
  always #20 clk = ~clk;
  dce_engine dce_engine_i (.clk(clk), .srst(srst), .armWrite(armWrite),
    .channelArmBit(channelArmBit), .abortReq(abortReq),
    .softRequestBit(softRequestBit), .trigIn(trigIn),
    .chan0ConfigPointer(16'h0020), .chan1to4ConfigPointer(16'h0000),
    .cpuReq(cpuReq), .cpuGnt(cpuGnt), .memReq(memReq),
    .memWrite(memWrite), .memWord(memWord), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .flagClear(flagClear),
    .completionFlagReg(flags), .armedState(armed), .irqReq(irqReq));
  dce_mem_model dce_mem_model_i (.clk(clk), .memReq(memReq),
    .memWrite(memWrite), .memWord(memWord), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic desc(input int a, input logic [63:0] d);
    for (int k = 0; k < 8; k++) dce_mem_model_i.mem[a + k] = d[63 - 8*k -: 8];
  endtask
  function automatic logic [15:0] rdw(input int a);
    rdw = {dce_mem_model_i.mem[a], dce_mem_model_i.mem[a + 1]};
  endfunction
  task automatic armCh(input logic [4:0] b, input logic ab);
    @(negedge clk);
    armWrite = 1;
    channelArmBit = b;
    abortReq = ab;
    @(negedge clk);
    armWrite = 0;
    channelArmBit = 0;
    abortReq = 0;
    // Triggers before the nine clock fetch ends are lost
    repeat (10) @(negedge clk);
  endtask
  // Trigger number 0 means a software request
  task automatic kick(input int ch, input int t);
    irqSeen = 0;
    @(negedge clk);
    if (t == 0) softRequestBit[ch] = 1;
    else trigIn[t] = 1;
    @(negedge clk);
    softRequestBit = 0;
    trigIn = 0;
    repeat (40) begin
      @(negedge clk);
      if (irqReq === 1'b1) irqSeen = 1;
      if (flags[ch] === 1'b1) break;
    end
    @(negedge clk);
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    irqSeen = 0;
    // Let the model fill memory before records are poked
    repeat (12) @(negedge clk);
    // Block, bytes, +1/+1, masked irq on, high prio
    desc(8'h00, 64'h0040_0080_0003_205e);
    desc(8'h20, 64'h0050_0090_200a_2056);
    desc(8'h08, 64'h0060_00a0_0001_0056);
    // Repeated single words, src -1, dst +2, trigger 5, low prio
    desc(8'h10, 64'h0072_00b0_0002_c5e8);
    // Single byte chained behind channel 3, normal prio
    desc(8'h18, 64'h0074_00c0_0001_0101);
    {dce_mem_model_i.mem[8'h40], dce_mem_model_i.mem[8'h41]} = 16'ha1b2;
    dce_mem_model_i.mem[8'h42] = 8'hc3;
    {dce_mem_model_i.mem[8'h50], dce_mem_model_i.mem[8'h51]} = 16'h0211;
    dce_mem_model_i.mem[8'h52] = 8'h22;
    dce_mem_model_i.mem[8'h60] = 8'h5a;
    {dce_mem_model_i.mem[8'h71], dce_mem_model_i.mem[8'h72]} = 16'h1122;
    dce_mem_model_i.mem[8'h73] = 8'h33;
    dce_mem_model_i.mem[8'h74] = 8'h66;
    srst = 0;
    armCh(5'h02, 0);
    check(armed, 5'h02);
    kick(1, 0);
    check(flags, 5'h02);
    check(armed, 5'h00);
    check(irqSeen, 1);
    for (int k = 0; k < 3; k++)
      check(dce_mem_model_i.mem[8'h80 + k],
        dce_mem_model_i.mem[8'h40 + k]);
    check(dce_mem_model_i.mem[8'h83], 8'hee);
    $display("test block done");
    armCh(5'h01, 0);
    kick(0, 0);
    check(flags, 5'h03);
    check(irqSeen, 0);
    for (int k = 0; k < 3; k++)
      check(dce_mem_model_i.mem[8'h90 + k],
        dce_mem_model_i.mem[8'h50 + k]);
    check(dce_mem_model_i.mem[8'h93], 8'hee);
    $display("test var_length_option done");
    armCh(5'h04, 0);
    check(armed, 5'h04);
    armCh(5'h04, 1);
    check(armed, 5'h00);
    kick(2, 0);
    check(flags, 5'h03);
    check(dce_mem_model_i.mem[8'ha0], 8'hee);
    $display("test abort done");
    armCh(5'h18, 0);
    check(armed, 5'h18);
    cpuReq = 1;
    kick(3, 5);
    check(cpuGnt, 1);
    check(rdw(8'hb0), 16'heeee);
    cpuReq = 0;
    repeat (6) @(negedge clk);
    check(rdw(8'hb0), 16'h2233);
    check(flags, 5'h03);
    kick(3, 5);
    check(rdw(8'hb2), 16'h1122);
    check(irqSeen, 1);
    flagClear = 5'h08;
    @(negedge clk);
    flagClear = 0;
    repeat (6) @(negedge clk);
    check(flags, 5'h13);
    check(armed, 5'h08);
    check(dce_mem_model_i.mem[8'hc0], 8'h66);
    dce_mem_model_i.mem[8'h73] = 8'h44;
    kick(3, 5);
    check(rdw(8'hb0), 16'h2244);
    $display("test repeat done");
    summarize();
  end
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
